// *** shared/prc_pkg.sv ***
// package for the performance report control block: register map, field
// positions, reset values, timing constants and the carrier structs.
// assumes a single 20 MHz clock domain and a 32-bit avalon-mm slave.
package prc_pkg;
    // clock rate and the one second report period
    localparam int CLK_HZ = 20000000;
    localparam int SEC_PERIOD_MS = 1000;
    localparam int SEC_CYCLES = (CLK_HZ / 1000) * SEC_PERIOD_MS;

    // register byte addresses (word aligned)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_MASK = 4'h8;
    localparam logic [3:0] ADDR_LINE = 4'hc;

    // control register field positions
    localparam int BIT_ADJ = 7;
    localparam int BIT_LOS_EN = 6;
    localparam int BIT_FAR = 5;
    localparam int NPR_HI = 4;
    localparam int NPR_LO = 3;
    localparam int BIT_CR = 2;
    localparam int APR_HI = 1;
    localparam int APR_LO = 0;
    localparam logic [7:0] CTRL_RESET = 8'h40;

    // report field codes
    localparam logic [1:0] RPT_OFF = 2'h0;
    localparam logic [1:0] RPT_ONCE = 2'h1;
    localparam logic [1:0] RPT_AUTO = 2'h2;

    // line status register fields
    localparam int BIT_SHORT = 0;
    localparam int BIT_AIS = 1;

    // event status bits
    localparam int EV_NPR = 0;
    localparam int EV_APR = 1;
    localparam int EV_LOS = 2;
    localparam int EV_N = 3;

    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // one outgoing performance report request
    typedef struct packed {
        logic valid;
        logic network;
        logic far_end;
        logic cr_bit;
    } prc_report_t;

    // avalon-mm request bundle
    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
    } prc_avreq_t;
endpackage

// *** hw/prc_sec_tick.sv ***
// one second tick generator for the periodic report modes.
// assumes the same clock and reset as the control block.
`timescale 1ns/1ps
module prc_sec_tick
    import prc_pkg::*;
#(
    parameter int PERIOD = SEC_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // run while any periodic mode is selected
    input wire logic run_i,
    // one-cycle pulse every PERIOD cycles of running
    output logic tick_o
);
    logic [31:0] cnt_reg; // cycles since the last tick
    logic [31:0] cnt_next;
    logic wrap; // terminal count reached

    assign wrap = (cnt_reg == 32'(PERIOD - 1));
    // restart from zero when stopped so the first report lands a full second later
    assign cnt_next = (!run_i || wrap) ? 32'h0 : cnt_reg + 32'h1;

    // counter and tick flop
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= 32'h0;
            tick_o <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_o <= run_i && wrap;
        end
    end
endmodule

// *** hw/prc_ctrl.sv ***
// performance report control register bank with avalon-mm slave,
// loss-of-signal pin control, build-out auto reduction and report triggers.
// assumes line status inputs come from pins or other clock domains.
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module prc_ctrl
    import prc_pkg::*;
#(
    parameter int SEC_PERIOD = SEC_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // avalon-mm slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // line status (asynchronous)
    input wire logic los_detect_i,
    input wire logic ais_sending_i,
    input wire logic short_haul_i,
    // selected build-out setting from the line setup
    input wire logic [4:0] line_equalizer_code_i,
    // receive loss-of-signal pin, two signals: level and output enable
    output logic rx_sigloss_pin_o,
    output logic rx_sigloss_pin_oe_o,
    // build-out actually applied
    output logic [4:0] line_equalizer_code_o,
    // report request towards the message builder
    output prc_report_t report_o,
    // interrupt
    output logic irq_o
);
    // synchronisers for the line status inputs
    logic [2:0] sync1_reg; // first stage, read only by second stage
    logic [2:0] sync2_reg;
    logic los_s, ais_s, short_s;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else begin
            sync1_reg <= {los_detect_i, ais_sending_i, short_haul_i};
            sync2_reg <= sync1_reg;
        end
    end
    assign los_s = sync2_reg[2];
    assign ais_s = sync2_reg[1];
    assign short_s = sync2_reg[0];

    // registers
    logic [7:0] ctrl_reg; // performance_report_control
    logic [EV_N-1:0] stat_reg; // sticky events, write one to clear
    logic [EV_N-1:0] mask_reg; // interrupt enables
    logic [EV_N-1:0] stat_next;
    logic [1:0] npr_prev_reg; // last written network field
    logic [1:0] apr_prev_reg; // last written auto field
    logic ack_reg; // answer phase of a bus access

    // bus decode
    logic req, wr_go, rd_go;
    logic sel_ctrl, sel_stat, sel_mask, sel_line;
    logic [31:0] rd_mux;
    assign req = avs_read_i || avs_write_i;
    // one wait cycle per access, write accepted when ack_reg is high, read data latched when it is low
    assign wr_go = avs_write_i && ack_reg;
    assign rd_go = avs_read_i && !ack_reg;
    assign sel_ctrl = (avs_address_i == ADDR_CTRL);
    assign sel_stat = (avs_address_i == ADDR_STAT);
    assign sel_mask = (avs_address_i == ADDR_MASK);
    assign sel_line = (avs_address_i == ADDR_LINE);
    assign rd_mux = sel_ctrl ? {24'h0, ctrl_reg} :
                    sel_stat ? {29'h0, stat_reg} :
                    sel_mask ? {29'h0, mask_reg} :
                    sel_line ? {30'h0, ais_s, short_s} : RD_UNMAPPED;

    // report triggers
    logic [1:0] npr_new, apr_new;
    logic npr_once, apr_once, npr_auto, apr_auto;
    logic sec_tick;
    logic npr_fire, apr_fire;
    assign npr_new = avs_writedata_i[NPR_HI:NPR_LO];
    assign apr_new = avs_writedata_i[APR_HI:APR_LO];
    // single shot only on a write of 01 whose preceding write left 00
    assign npr_once = wr_go && sel_ctrl && npr_new == RPT_ONCE
                      && npr_prev_reg == RPT_OFF;
    assign apr_once = wr_go && sel_ctrl && apr_new == RPT_ONCE
                      && apr_prev_reg == RPT_OFF;
    assign npr_auto = ctrl_reg[NPR_HI:NPR_LO] == RPT_AUTO;
    assign apr_auto = ctrl_reg[APR_HI:APR_LO] == RPT_AUTO;
    // codes 00 and 11 never reach either fire term
    assign npr_fire = npr_once || (npr_auto && sec_tick);
    assign apr_fire = apr_once || (apr_auto && sec_tick);

    prc_sec_tick #(
        .PERIOD(SEC_PERIOD)
    ) u_tick (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .run_i(npr_auto || apr_auto),
        .tick_o(sec_tick)
    );

    // los edge for the event register
    logic los_prev_reg;
    logic [EV_N-1:0] ev_set;
    assign ev_set = {los_s && !los_prev_reg, apr_fire, npr_fire};
    // hardware set wins over a software clear in the same cycle
    assign stat_next = ev_set | (stat_reg & ~((wr_go && sel_stat) ?
                       avs_writedata_i[EV_N-1:0] : {EV_N{1'b0}}));

    // register file and bus answer
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_reg <= CTRL_RESET;
            mask_reg <= {EV_N{1'b0}};
            stat_reg <= {EV_N{1'b0}};
            npr_prev_reg <= RPT_OFF;
            apr_prev_reg <= RPT_OFF;
            ack_reg <= 1'b0;
            los_prev_reg <= 1'b0;
            avs_readdata_o <= 32'h0;
        end else begin
            ack_reg <= req && !ack_reg;
            los_prev_reg <= los_s;
            stat_reg <= stat_next;
            if (wr_go && sel_ctrl) begin
                ctrl_reg <= avs_writedata_i[7:0];
                npr_prev_reg <= npr_new;
                apr_prev_reg <= apr_new;
            end
            if (wr_go && sel_mask) begin
                mask_reg <= avs_writedata_i[EV_N-1:0];
            end
            if (rd_go) begin
                avs_readdata_o <= rd_mux;
            end
        end
    end

    // waitrequest high unless answering; idle bus keeps it high too
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !(req && !ack_reg);
        end
    end

    // outputs toward the line and message builder
    logic adjust_on;
    logic [4:0] lbo_next;
    prc_report_t rep_next;
    logic [7:0] ctrl_now; // control value in force once this edge has passed
    // a report started by a control write must carry the bits written with it,
    // not the stale ones; otherwise far-end and c/r would lag one write behind
    assign ctrl_now = (wr_go && sel_ctrl) ? avs_writedata_i[7:0] : ctrl_reg;
    // reduction only when enabled, sending AIS and in short haul mode
    assign adjust_on = ctrl_reg[BIT_ADJ] && ais_s && short_s;
    // one setting lower, never below the lowest code
    assign lbo_next = (adjust_on && line_equalizer_code_i != 5'h0) ?
                      line_equalizer_code_i - 5'h1 : line_equalizer_code_i;
    assign rep_next.valid = npr_fire || apr_fire;
    assign rep_next.network = npr_fire;
    assign rep_next.far_end = ctrl_now[BIT_FAR];
    assign rep_next.cr_bit = ctrl_now[BIT_CR];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_sigloss_pin_o <= 1'b0;
            rx_sigloss_pin_oe_o <= 1'b0;
            line_equalizer_code_o <= 5'h0;
            report_o <= '0;
            irq_o <= 1'b0;
        end else begin
            rx_sigloss_pin_oe_o <= ctrl_reg[BIT_LOS_EN];
            rx_sigloss_pin_o <= los_s;
            line_equalizer_code_o <= lbo_next;
            report_o <= rep_next;
            irq_o <= |(stat_next & mask_reg);
        end
    end

    // checks
    // report fields are compared with the control register as it stands when
    // the pulse is out, which already includes the write that caused it
    sequence s_once_write;
        wr_go && sel_ctrl && npr_new == RPT_ONCE && npr_prev_reg == RPT_OFF;
    endsequence
    AST_LOS_TRISTATE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !ctrl_reg[BIT_LOS_EN] |=> !rx_sigloss_pin_oe_o)
        else $error("loss pin driven while disabled");
    AST_LOS_LEVEL: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctrl_reg[BIT_LOS_EN] |=> rx_sigloss_pin_o == $past(los_s))
        else $error("loss pin level wrong");
    AST_NPR_ONCE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_once_write |=> report_o.valid && report_o.network)
        else $error("single network report missing");
    AST_NPR_IDLE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!npr_once && ctrl_reg[NPR_HI:NPR_LO] != RPT_AUTO) |=> !report_o.network)
        else $error("network report without cause");
    AST_NPR_AUTO: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (npr_auto && sec_tick) |=> report_o.network)
        else $error("periodic network report missing");
    AST_CR_BIT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        report_o.valid |-> report_o.cr_bit == ctrl_reg[BIT_CR])
        else $error("report c/r bit mismatch");
    AST_FAR_END: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        report_o.valid |-> report_o.far_end == ctrl_reg[BIT_FAR])
        else $error("report far-end mismatch");
    AST_APR_ONCE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        apr_once |=> report_o.valid)
        else $error("single auto report missing");
    AST_APR_IDLE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (report_o.valid && !report_o.network) |-> $past(apr_once || apr_auto))
        else $error("auto report without cause");
    AST_LBO_SHORT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !short_s |=> line_equalizer_code_o == $past(line_equalizer_code_i))
        else $error("build-out changed outside short haul");
    AST_LBO_DROP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (adjust_on && line_equalizer_code_i != 5'h0) |=>
        line_equalizer_code_o == $past(line_equalizer_code_i) - 5'h1)
        else $error("build-out not lowered");
    AST_REPORT_SRC: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        report_o.valid |-> $past(npr_fire || apr_fire))
        else $error("report with no trigger");
endmodule

// *** test/prc_ctrl_tb_top.sv ***
// self-checking bench for the performance report control block.
// assumes the 20 MHz clock, short SEC_PERIOD of 20 and the avalon-mm slave.
`timescale 1ns/1ps
module prc_ctrl_tb_top
    import prc_pkg::*;
;
    localparam int SEC = 20; // shortened one second period
    logic clk = 1'b0; // 50 ns clock
    logic arst_n; // async reset
    logic [3:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wait_o;
    logic los;
    logic ais;
    logic shrt;
    logic [4:0] eq_in;
    logic [4:0] eq_out;
    logic pin;
    logic pin_oe;
    logic irq;
    prc_report_t rep;
    prc_report_t last_rep; // last report pulse seen
    int n_mismatch;
    int n_tests;
    int n_rep; // report pulses counted

    always #25 clk = ~clk;

    prc_ctrl #(.SEC_PERIOD(SEC)) DUT (
        .clk_i(clk), .arst_n_i(arst_n),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .los_detect_i(los), .ais_sending_i(ais), .short_haul_i(shrt),
        .line_equalizer_code_i(eq_in), .rx_sigloss_pin_o(pin),
        .rx_sigloss_pin_oe_o(pin_oe), .line_equalizer_code_o(eq_out),
        .report_o(rep), .irq_o(irq)
    );

    // count report pulses at the falling edge, where the registered pulse is settled
    always @(negedge clk) begin
        if (rep.valid === 1'b1) begin
            n_rep++;
            last_rep = rep;
        end
    end

    // verdict and end of run
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one bus access; waitrequest and read data are taken at the rising edge,
    // before that edge's updates land, and the request is dropped at that edge
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int k;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd <= ~w;
        wr <= w;
        k = 0;
        @(posedge clk);
        while (wait_o !== 1'b0 && k < 20) begin
            @(posedge clk);
            k++;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (k >= 20) begin
            n_mismatch++;
            $display("wrong value waitrequest expected 0 seen %b", wait_o);
            conclude();
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        acc(1'b0, a, 32'h0, q);
        chk(what, e, q);
    endtask

    // wait n cycles and stop at a falling edge, where outputs are settled
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // periodic and silent codes with the pulses expected in 110 cycles
    logic [31:0] codes [4] = '{32'h50, 32'h42, 32'h58, 32'h43};
    int exp_n [4] = '{5, 5, 0, 0};

    initial begin
        arst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        los = 1'b0;
        ais = 1'b0;
        shrt = 1'b0;
        eq_in = 5'h05;
        n_mismatch = 0;
        n_tests = 0;
        n_rep = 0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        // reset value and pin behaviour
        rd_chk("ctrl reset", ADDR_CTRL, 32'h40);
        cyc(4);
        chk("pin oe", 32'h1, 32'(pin_oe));
        chk("pin low", 32'h0, 32'(pin));
        @(posedge clk) los <= 1'b1;
        cyc(5);
        chk("pin high", 32'h1, 32'(pin));
        rd_chk("status los", ADDR_STAT, 32'h4);
        wr_reg(ADDR_CTRL, 32'h0);
        cyc(4);
        chk("pin oe off", 32'h0, 32'(pin_oe));
        @(posedge clk) los <= 1'b0;
        $display("test sigloss pin done");
        // build-out reduction during ais, only in short haul
        wr_reg(ADDR_CTRL, 32'hc0);
        @(posedge clk) begin
            ais <= 1'b1;
            shrt <= 1'b1;
        end
        cyc(5);
        chk("buildout short", 32'h4, 32'(eq_out));
        @(posedge clk) shrt <= 1'b0;
        cyc(5);
        chk("buildout long", 32'h5, 32'(eq_out));
        rd_chk("line status", ADDR_LINE, 32'h2);
        @(posedge clk) ais <= 1'b0;
        $display("test buildout done");
        // single reports, c/r and far-end copied
        wr_reg(ADDR_CTRL, 32'h40);
        n_rep = 0;
        wr_reg(ADDR_CTRL, 32'h6c);
        cyc(3);
        chk("net once", 32'h1, 32'(n_rep));
        chk("net kind", 32'h1, 32'(last_rep.network));
        chk("far set", 32'h1, 32'(last_rep.far_end));
        chk("cr set", 32'h1, 32'(last_rep.cr_bit));
        wr_reg(ADDR_CTRL, 32'h6c);
        cyc(3);
        chk("net repeat", 32'h1, 32'(n_rep));
        wr_reg(ADDR_CTRL, 32'h40);
        wr_reg(ADDR_CTRL, 32'h41);
        cyc(3);
        chk("auto once", 32'h2, 32'(n_rep));
        chk("auto kind", 32'h0, 32'(last_rep.network));
        chk("far clear", 32'h0, 32'(last_rep.far_end));
        chk("cr clear", 32'h0, 32'(last_rep.cr_bit));
        $display("test single reports done");
        // periodic reports and silent codes
        for (int i = 0; i < 4; i++) begin
            wr_reg(ADDR_CTRL, 32'h40);
            wr_reg(ADDR_CTRL, codes[i]);
            n_rep = 0;
            cyc(110);
            chk("periodic count", 32'(exp_n[i]), 32'(n_rep));
        end
        $display("test periodic reports done");
        // interrupt raise, mask and clear
        wr_reg(ADDR_CTRL, 32'h40);
        wr_reg(ADDR_STAT, 32'h7);
        wr_reg(ADDR_MASK, 32'h1);
        cyc(3);
        chk("irq idle", 32'h0, 32'(irq));
        wr_reg(ADDR_CTRL, 32'h48);
        cyc(4);
        chk("irq set", 32'h1, 32'(irq));
        rd_chk("status net", ADDR_STAT, 32'h1);
        wr_reg(ADDR_MASK, 32'h0);
        cyc(3);
        chk("irq masked", 32'h0, 32'(irq));
        wr_reg(ADDR_MASK, 32'h1);
        cyc(3);
        chk("irq unmasked", 32'h1, 32'(irq));
        wr_reg(ADDR_STAT, 32'h1);
        cyc(3);
        chk("irq cleared", 32'h0, 32'(irq));
        rd_chk("unmapped", 4'h2, 32'h0);
        $display("test interrupt done");
        conclude();
    end
endmodule
